// ===== flash_cmd_map.svh
// Summary of operation
// - each read strobe in read-status mode returns freshly computed status
// - suspend code then read-status; poll until ready flag is one
// - erase done before suspend: suspended flag zero, read-array acts normally
// - resume continues erase and leaves bank in read-status mode
// - read-status accepted just before or after a resume, same effect
// - setup then protect code marks the addressed block protected
// - setup then confirm code clears the addressed block's protection
// - after signature command, a read at offset 02h in a block returns its protection state
// - read-array code returns the bank to array reads
// - after program data is accepted, reads return the status value
// - factory setup failure sets program error with its cause, else program phase
// - factory data comes in groups of exactly 32 words, buffered by device
// - buffer busy flag set per group, cleared when ready for more data
// - all-ones word outside first block ends the factory program
// - query returns 03h 00h 80h 00h at 14Ah through 14Dh
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define CMD_READ_ARRAY  8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_SIGNATURE   8'h90
`define CMD_CFI_QUERY   8'h98
`define CMD_CLEAR_STAT  8'h50
`define CMD_PROGRAM     8'h40
`define CMD_PROGRAM_ALT 8'h10
`define CMD_OTP_PROGRAM 8'hC0
`define CMD_ERASE       8'h20
`define CMD_SUSPEND     8'hB0
`define CMD_CONFIRM     8'hD0
`define CMD_CONFIG      8'h60
`define CMD_PROTECT     8'h01
`define CMD_FACTORY     8'h80
`define EXIT_WORD       16'hFFFF
`define ARRAY_FILL      16'hFFFF
`define ADDR_W          24
`define DATA_W          16
`define BLK_LSB         20
`define BLK_W           4
`define BLK_COUNT       16
`define PROT_RESET      16'h0000
`define SIG_MFR_OFF     8'h00
`define SIG_DEV_OFF     8'h01
`define SIG_PROT_OFF    8'h02
`define CFI_OFF_W       12
`define CFI_R2B2_0      12'h14A
`define CFI_R2B2_1      12'h14B
`define CFI_R2B2_2      12'h14C
`define CFI_R2B2_3      12'h14D
`define CFI_VAL_0       16'h0003
`define CFI_VAL_1       16'h0000
`define CFI_VAL_2       16'h0080
`define CFI_VAL_3       16'h0000
`define BEFP_GROUP      6'h20
`define TMR_W           16
`define CLK_NS          10
`define PROG_TIME_NS    1000
`define OTP_TIME_NS     1000
`define ERASE_TIME_NS   20000
`define BEFP_TIME_NS    2000
`define NS_TO_CYC(t)    (((t) + `CLK_NS - 1) / `CLK_NS)
`define ST_READY_BIT    7
`define ST_ESUSP_BIT    6
`define ST_PERR_BIT     4
`define ST_VPP_BIT      3
`define ST_PROT_BIT     1
`define ST_BBUSY_BIT    0
`endif

// ===== flash_cmd_pkg.sv
`include "flash_cmd_map.svh"
package flash_cmd_pkg;
   typedef enum logic [3:0] {
      ST_READY      = 4'h0,
      ST_PROG_SETUP = 4'h1,
      ST_PROG_BUSY  = 4'h2,
      ST_OTP_SETUP  = 4'h3,
      ST_OTP_BUSY   = 4'h4,
      ST_ERASE_SET  = 4'h5,
      ST_ERASE_BUSY = 4'h6,
      ST_ERASE_SUSP = 4'h7,
      ST_PROT_SETUP = 4'h8,
      ST_BEFP_SETUP = 4'h9,
      ST_BEFP_LOAD  = 4'hA,
      ST_BEFP_PROG  = 4'hB
   } state_type;
   typedef enum logic [1:0] {
      MODE_ARRAY  = 2'h0,
      MODE_STATUS = 2'h1,
      MODE_SIG    = 2'h2,
      MODE_CFI    = 2'h3
   } mode_type;
   typedef struct packed {
      state_type              state;
      mode_type               mode;
      logic                   perr;
      logic                   vinv;
      logic                   pblk;
      logic [`BLK_COUNT-1:0]  prot;
      logic [`BLK_W-1:0]      wa1_blk;
      logic [5:0]             cnt;
      logic [2:0]             vsync;
      logic                   vpp_ok;
      logic [`DATA_W-1:0]     rdata;
      logic                   rdy;
   } ctrl_type;
   typedef struct packed {
      logic [`TMR_W-1:0] cnt;
      logic              done;
   } timer_type;
endpackage : flash_cmd_pkg

// ===== op_timer_if.sv
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
interface op_timer_if;
   logic              start;
   logic              hold;
   logic [`TMR_W-1:0] len;
   logic              done;
   modport ctl (output start, output hold, output len, input done);
   modport tmr (input start, input hold, input len, output done);
endinterface : op_timer_if

// ===== op_timer.sv
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module op_timer
   import flash_cmd_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   op_timer_if.tmr   tmr_bus
);
   timer_type r_reg;
   timer_type r_next;

   // hold freezes the count, so a suspended erase keeps its remaining time
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (tmr_bus.start) begin
         r_next.cnt = tmr_bus.len;
      end else if (!tmr_bus.hold && r_reg.cnt != '0) begin
         r_next.cnt = r_reg.cnt - 1'b1;
         r_next.done = (r_reg.cnt == `TMR_W'(1));
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tmr_bus.done = r_reg.done;
endmodule : op_timer

// ===== flash_command_sequences.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module flash_command_sequences
   import flash_cmd_pkg::*;
#(
   parameter logic [`DATA_W-1:0] MFR_CODE = 16'h00A5, // arbitrary value
   parameter logic [`DATA_W-1:0] DEV_CODE = 16'h0C3C  // arbitrary value
)(
   input  wire logic               i_clk,
   input  wire logic               i_arst_n,
   input  wire logic [`ADDR_W-1:0] i_addr,
   input  wire logic [`DATA_W-1:0] i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   input  wire logic               i_vpp_ok,
   output logic      [`DATA_W-1:0] o_rdata,
   output logic                    o_ready
);
   ctrl_type           r_reg;
   ctrl_type           r_next;
   state_type          st;
   logic [7:0]         cmd;
   logic [`BLK_W-1:0]  blk;
   logic               vbad;
   logic               pbad;
   logic [7:0]         sts;
   logic [`DATA_W-1:0] rd_val;

   op_timer_if tbus ();

   op_timer u_timer (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .tmr_bus  (tbus)
   );

   function automatic logic is_ready(state_type s);
      return !(s == ST_PROG_BUSY || s == ST_OTP_BUSY || s == ST_ERASE_BUSY ||
               s == ST_BEFP_LOAD || s == ST_BEFP_PROG);
   endfunction : is_ready

   assign cmd  = i_wdata[7:0];
   assign blk  = i_addr[`BLK_LSB +: `BLK_W];
   assign vbad = !r_reg.vpp_ok;
   assign pbad = r_reg.prot[blk];

   // status is rebuilt from live state on every read strobe
   always_comb begin
      sts = '0;
      sts[`ST_READY_BIT] = is_ready(r_reg.state);
      sts[`ST_ESUSP_BIT] = (r_reg.state == ST_ERASE_SUSP);
      sts[`ST_PERR_BIT]  = r_reg.perr;
      sts[`ST_VPP_BIT]   = r_reg.vinv;
      sts[`ST_PROT_BIT]  = r_reg.pblk;
      sts[`ST_BBUSY_BIT] = (r_reg.state == ST_BEFP_PROG);
   end

   always_comb begin
      rd_val = '0;
      case (r_reg.mode)
         MODE_ARRAY:  rd_val = `ARRAY_FILL;
         MODE_STATUS: rd_val = {8'h00, sts};
         MODE_SIG: begin
            if (i_addr[7:0] == `SIG_MFR_OFF) begin
               rd_val = MFR_CODE;
            end else if (i_addr[7:0] == `SIG_DEV_OFF) begin
               rd_val = DEV_CODE;
            end else if (i_addr[7:0] == `SIG_PROT_OFF) begin
               rd_val = {{(`DATA_W-1){1'b0}}, pbad};
            end
         end
         MODE_CFI: begin
            case (i_addr[`CFI_OFF_W-1:0])
               `CFI_R2B2_0: rd_val = `CFI_VAL_0;
               `CFI_R2B2_1: rd_val = `CFI_VAL_1;
               `CFI_R2B2_2: rd_val = `CFI_VAL_2;
               `CFI_R2B2_3: rd_val = `CFI_VAL_3;
               default:     rd_val = '0;
            endcase
         end
         default: rd_val = '0;
      endcase
   end

   always_comb begin
      r_next = r_reg;
      tbus.start = 1'b0;
      tbus.len = '0;
      tbus.hold = 1'b0;
      // pin sync: change taken only when second and third stages agree
      r_next.vsync = {r_reg.vsync[1:0], i_vpp_ok};
      if (r_reg.vsync[1] == r_reg.vsync[2]) begin
         r_next.vpp_ok = r_reg.vsync[2];
      end
      r_next.rdata = i_rd ? rd_val : '0;
      // completion wins over a same-cycle suspend: erase stays finished
      st = r_reg.state;
      if (tbus.done) begin
         case (r_reg.state)
            ST_PROG_BUSY, ST_OTP_BUSY, ST_ERASE_BUSY: st = ST_READY;
            ST_BEFP_PROG: begin
               st = ST_BEFP_LOAD;
               r_next.cnt = '0;
            end
            default: st = r_reg.state;
         endcase
      end
      r_next.state = st;
      if (i_wr) begin
         case (st)
            ST_READY, ST_ERASE_SUSP: begin
               case (cmd)
                  `CMD_READ_ARRAY:  r_next.mode = MODE_ARRAY;
                  `CMD_READ_STATUS: r_next.mode = MODE_STATUS;
                  `CMD_SIGNATURE:   r_next.mode = MODE_SIG;
                  `CMD_CFI_QUERY:   r_next.mode = MODE_CFI;
                  `CMD_CLEAR_STAT: begin
                     r_next.perr = 1'b0;
                     r_next.vinv = 1'b0;
                     r_next.pblk = 1'b0;
                  end
                  `CMD_CONFIG: r_next.state = ST_PROT_SETUP;
                  `CMD_SUSPEND: r_next.mode = MODE_STATUS;
                  `CMD_CONFIRM: begin
                     if (st == ST_ERASE_SUSP) begin
                        r_next.state = ST_ERASE_BUSY;
                        r_next.mode = MODE_STATUS;
                     end
                  end
                  `CMD_PROGRAM, `CMD_PROGRAM_ALT: begin
                     if (st == ST_READY) begin
                        r_next.state = ST_PROG_SETUP;
                     end
                  end
                  `CMD_OTP_PROGRAM: begin
                     if (st == ST_READY) begin
                        r_next.state = ST_OTP_SETUP;
                     end
                  end
                  `CMD_ERASE: begin
                     if (st == ST_READY) begin
                        r_next.state = ST_ERASE_SET;
                     end
                  end
                  `CMD_FACTORY: begin
                     if (st == ST_READY) begin
                        r_next.state = ST_BEFP_SETUP;
                        r_next.wa1_blk = blk;
                     end
                  end
                  default: r_next.mode = r_reg.mode;
               endcase
            end
            ST_PROG_SETUP, ST_OTP_SETUP: begin
               r_next.mode = MODE_STATUS;
               if (vbad) begin
                  r_next.perr = 1'b1;
                  r_next.vinv = 1'b1;
                  r_next.state = ST_READY;
               end else if (pbad && st == ST_PROG_SETUP) begin
                  r_next.perr = 1'b1;
                  r_next.pblk = 1'b1;
                  r_next.state = ST_READY;
               end else if (st == ST_PROG_SETUP) begin
                  r_next.state = ST_PROG_BUSY;
                  tbus.start = 1'b1;
                  tbus.len = `TMR_W'(`NS_TO_CYC(`PROG_TIME_NS));
               end else begin
                  r_next.state = ST_OTP_BUSY;
                  tbus.start = 1'b1;
                  tbus.len = `TMR_W'(`NS_TO_CYC(`OTP_TIME_NS));
               end
            end
            ST_ERASE_SET: begin
               r_next.mode = MODE_STATUS;
               r_next.state = ST_READY;
               if (cmd == `CMD_CONFIRM) begin
                  if (vbad) begin
                     r_next.vinv = 1'b1;
                  end else if (pbad) begin
                     r_next.pblk = 1'b1;
                  end else begin
                     r_next.state = ST_ERASE_BUSY;
                     tbus.start = 1'b1;
                     tbus.len = `TMR_W'(`NS_TO_CYC(`ERASE_TIME_NS));
                  end
               end
            end
            ST_PROG_BUSY, ST_OTP_BUSY, ST_ERASE_BUSY: begin
               if (cmd == `CMD_READ_STATUS) begin
                  r_next.mode = MODE_STATUS;
               end else if (cmd == `CMD_SUSPEND && st == ST_ERASE_BUSY) begin
                  r_next.state = ST_ERASE_SUSP;
                  r_next.mode = MODE_STATUS;
               end
            end
            ST_PROT_SETUP: begin
               r_next.state = ST_READY;
               if (cmd == `CMD_PROTECT) begin
                  r_next.prot[blk] = 1'b1;
               end else if (cmd == `CMD_CONFIRM) begin
                  r_next.prot[blk] = 1'b0;
               end
            end
            ST_BEFP_SETUP: begin
               r_next.mode = MODE_STATUS;
               r_next.state = ST_READY;
               if (cmd == `CMD_CONFIRM) begin
                  if (vbad) begin
                     r_next.perr = 1'b1;
                     r_next.vinv = 1'b1;
                  end else if (r_reg.prot[r_reg.wa1_blk]) begin
                     r_next.perr = 1'b1;
                     r_next.pblk = 1'b1;
                  end else begin
                     r_next.state = ST_BEFP_LOAD;
                     r_next.cnt = '0;
                  end
               end
            end
            ST_BEFP_LOAD: begin
               if (blk == r_reg.wa1_blk) begin
                  // a partial group at exit is dropped, not programmed
                  if (r_next.cnt == `BEFP_GROUP - 6'h01) begin
                     r_next.state = ST_BEFP_PROG;
                     tbus.start = 1'b1;
                     tbus.len = `TMR_W'(`NS_TO_CYC(`BEFP_TIME_NS));
                     r_next.cnt = '0;
                  end else begin
                     r_next.cnt = r_next.cnt + 6'h01;
                  end
               end else if (i_wdata == `EXIT_WORD) begin
                  r_next.state = ST_READY;
               end
            end
            default: r_next.state = st;
         endcase
      end
      r_next.rdy = is_ready(r_next.state);
      // freeze from the suspend edge on, so a last tick cannot be lost in suspend
      tbus.hold = (r_next.state == ST_ERASE_SUSP);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r_reg <= '{state: ST_READY, mode: MODE_ARRAY, prot: `PROT_RESET, rdy: 1'b1, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_rdata = r_reg.rdata;
   assign o_ready = r_reg.rdy;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   read_data_slot_a: assert property (!i_rd |=> o_rdata == '0)
      else $error("read data outside its slot");
   status_fresh_a: assert property (
      i_rd && r_reg.mode == MODE_STATUS |=> o_rdata[7:0] == $past(sts))
      else $error("status read not current");
   suspend_take_a: assert property (
      r_reg.state == ST_ERASE_BUSY && !tbus.done && i_wr && cmd == `CMD_SUSPEND
      |=> r_reg.state == ST_ERASE_SUSP && o_ready ##1 !tbus.done)
      else $error("suspend not taken");
   done_no_susp_a: assert property (
      r_reg.state == ST_ERASE_BUSY && tbus.done |=> r_reg.state != ST_ERASE_SUSP)
      else $error("finished erase shows suspended");
   resume_status_a: assert property (
      r_reg.state == ST_ERASE_SUSP && i_wr && cmd == `CMD_CONFIRM
      |=> r_reg.state == ST_ERASE_BUSY && r_reg.mode == MODE_STATUS && !o_ready)
      else $error("resume did not restart erase");
   protect_set_a: assert property (
      r_reg.state == ST_PROT_SETUP && i_wr && cmd == `CMD_PROTECT
      |=> r_reg.prot[$past(blk)])
      else $error("block not protected");
   unprotect_a: assert property (
      r_reg.state == ST_PROT_SETUP && i_wr && cmd == `CMD_CONFIRM
      |=> !r_reg.prot[$past(blk)])
      else $error("block still protected");
   prog_status_a: assert property (
      r_reg.state == ST_PROG_SETUP && i_wr |=> r_reg.mode == MODE_STATUS)
      else $error("program data left status mode off");
   befp_group_a: assert property (
      r_reg.state == ST_BEFP_LOAD && !tbus.done && i_wr && blk == r_reg.wa1_blk
      && r_reg.cnt == `BEFP_GROUP - 6'h01 |=> r_reg.state == ST_BEFP_PROG ##0 !o_ready)
      else $error("group of words did not start programming");
   befp_exit_a: assert property (
      r_reg.state == ST_BEFP_LOAD && i_wr && blk != r_reg.wa1_blk
      && i_wdata == `EXIT_WORD |=> r_reg.state == ST_READY && o_ready)
      else $error("exit word ignored");
   cfi_value_a: assert property (
      i_rd && r_reg.mode == MODE_CFI && i_addr[`CFI_OFF_W-1:0] == `CFI_R2B2_2
      |=> o_rdata == `CFI_VAL_2)
      else $error("query value wrong");
   busy_ready_a: assert property (
      r_reg.state == ST_ERASE_BUSY |-> !o_ready)
      else $error("ready during erase");
   susp_ready_a: assert property (
      r_reg.state == ST_ERASE_SUSP |-> o_ready && sts[`ST_ESUSP_BIT])
      else $error("suspended erase not shown ready");
   status_resume_a: assert property (
      r_reg.state == ST_ERASE_BUSY && !tbus.done && i_wr && cmd == `CMD_READ_STATUS
      |=> r_reg.state == ST_ERASE_BUSY && r_reg.mode == MODE_STATUS)
      else $error("status command disturbed erase");
   array_mode_a: assert property (
      r_reg.state == ST_READY && i_wr && cmd == `CMD_READ_ARRAY |=> r_reg.mode == MODE_ARRAY)
      else $error("array mode not entered");
   sig_prot_read_a: assert property (
      i_rd && r_reg.mode == MODE_SIG && i_addr[7:0] == `SIG_PROT_OFF
      |=> o_rdata == {{(`DATA_W-1){1'b0}}, $past(pbad)})
      else $error("protection state read wrong");
   otp_status_a: assert property (
      r_reg.state == ST_OTP_SETUP && i_wr |=> r_reg.mode == MODE_STATUS)
      else $error("otp data left status mode off");
   setup_vpp_err_a: assert property (
      r_reg.state == ST_BEFP_SETUP && i_wr && cmd == `CMD_CONFIRM && vbad
      |=> r_reg.perr && r_reg.vinv && o_ready)
      else $error("factory voltage error missing");
   setup_prot_err_a: assert property (
      r_reg.state == ST_BEFP_SETUP && i_wr && cmd == `CMD_CONFIRM && !vbad
      && r_reg.prot[r_reg.wa1_blk] |=> r_reg.perr && r_reg.pblk && o_ready)
      else $error("factory protect error missing");
   bbusy_clear_a: assert property (
      r_reg.state == ST_BEFP_PROG && tbus.done |=> r_reg.state == ST_BEFP_LOAD && r_reg.cnt == '0)
      else $error("buffer busy not cleared");
   cfi_first_a: assert property (
      i_rd && r_reg.mode == MODE_CFI && i_addr[`CFI_OFF_W-1:0] == `CFI_R2B2_0
      |=> o_rdata == `CFI_VAL_0)
      else $error("first query value wrong");

   susp_resume_c: cover property (
      r_reg.state == ST_ERASE_SUSP ##1 r_reg.state == ST_ERASE_BUSY);
   befp_group_c: cover property (
      r_reg.state == ST_BEFP_PROG ##1 r_reg.state == ST_BEFP_LOAD);
   prog_error_c: cover property (r_reg.state == ST_PROG_SETUP ##1 r_reg.perr);
   befp_exit_c: cover property (
      r_reg.state == ST_BEFP_LOAD ##1 r_reg.state == ST_READY);
   unprotect_c: cover property (
      r_reg.state == ST_PROT_SETUP ##1 r_reg.prot == '0);
endmodule : flash_command_sequences

// ===== flash_host_model.sv
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module flash_host_model (
   input  wire logic               i_clk,
   input  wire logic [`DATA_W-1:0] i_rdata,
   output logic      [`ADDR_W-1:0] o_addr,
   output logic      [`DATA_W-1:0] o_wdata,
   output logic                    o_wr,
   output logic                    o_rd
);
   initial begin
      o_addr  = '0;
      o_wdata = '0;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end
   // one-cycle write strobe; data lines scrambled once released
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_wdata <= ~d;
   endtask : wr
   // answer stands only in the cycle after the strobe, so take it mid-cycle
   task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      @(negedge i_clk);
      d = i_rdata;
   endtask : rd
endmodule : flash_host_model

// ===== flash_command_sequences_tb.sv
`timescale 1ns/100ps
`include "flash_cmd_map.svh"
module flash_command_sequences_tb
   import flash_cmd_pkg::*;
;
   logic               i_clk;
   logic               i_arst_n;
   logic               i_vpp_ok;
   logic [`ADDR_W-1:0] addr;
   logic [`DATA_W-1:0] wdata;
   logic [`DATA_W-1:0] rdata;
   logic               wr;
   logic               rd;
   logic               ready;
   logic [`DATA_W-1:0] got;
   int                 failures;
   int                 n_checks;
   int                 seed;
   int                 prot[16];
   logic [`DATA_W-1:0] cfi_q[$];

   flash_command_sequences DUT (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .i_vpp_ok(i_vpp_ok), .o_rdata(rdata), .o_ready(ready));
   flash_host_model host (
      .i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   function automatic logic [`ADDR_W-1:0] ba(input int b);
      return {b[3:0], 20'h00000};
   endfunction : ba
   // expected status word built from the flag positions
   function automatic logic [`DATA_W-1:0] st(input int r, s, pe, v, pb, bb);
      return 16'(r * 128 + s * 64 + pe * 16 + v * 8 + pb * 2 + bb);
   endfunction : st

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [`DATA_W-1:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk
   task automatic cmd(input int b, input logic [7:0] c);
      host.wr(ba(b), {8'h00, c});
   endtask : cmd
   task automatic rdchk(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] e,
                        input string m);
      host.rd(a, got);
      chk(got, e, m);
   endtask : rdchk
   // bounded status polling; a fresh read each time
   task automatic poll(input int b, input int bn, input logic v);
      for (int i = 0; i < 3000; i++) begin
         host.rd(ba(b), got);
         if (got[bn] === v) begin
            return;
         end
      end
      failures++;
      $display("unexpected at %0t: poll bound used up", $time);
      give_verdict();
   endtask : poll

   initial begin
      i_arst_n = 1'b0;
      i_vpp_ok = 1'b1;
      failures = 0;
      n_checks = 0;
      seed     = 32'h9E7D;
      foreach (prot[i]) prot[i] = 0;
      cfi_q = {16'h0003, 16'h0000, 16'h0080, 16'h0000};
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(negedge i_clk);
      chk(16'(ready), 16'h0001, "ready after reset");
      chk(rdata, 16'h0000, "read data idle");
      // voltage sync needs a few edges before program or erase
      repeat (6) @(posedge i_clk);
      $display("test reset done");
      cmd(0, `CMD_CFI_QUERY);
      for (int k = 0; k < 4; k++) begin
         rdchk(24'(32'h14A + k), cfi_q[k], "cfi value");
      end
      rdchk(24'h00014E, 16'h0000, "cfi past table");
      cmd(0, `CMD_READ_ARRAY);
      $display("test cfi done");
      for (int p = 0; p < 2; p++) begin
         cmd(2, `CMD_CONFIG);
         cmd(2, (p == 0) ? `CMD_PROTECT : `CMD_CONFIRM);
         prot[2] = (p == 0) ? 1 : 0;
         cmd(2, `CMD_SIGNATURE);
         rdchk(ba(2) + 24'h000002, 16'(prot[2]), "protect state");
         rdchk(ba(3) + 24'h000002, 16'(prot[3]), "other block state");
         cmd(2, `CMD_READ_ARRAY);
         rdchk(ba(2), `ARRAY_FILL, "array read");
      end
      $display("test protect done");
      host.wr(ba(0) + 24'h000010, {8'h00, `CMD_OTP_PROGRAM});
      host.wr(ba(0) + 24'h000010, 16'($random(seed)));
      rdchk(ba(0) + 24'h000010, st(0, 0, 0, 0, 0, 0), "otp busy");
      poll(0, `ST_READY_BIT, 1'b1);
      chk(got, st(1, 0, 0, 0, 0, 0), "otp done");
      $display("test otp done");
      for (int o = 0; o < 2; o++) begin
         cmd(1, `CMD_ERASE);
         cmd(1, `CMD_CONFIRM);
         @(negedge i_clk);
         chk(16'(ready), 16'h0000, "erase busy");
         cmd(1, `CMD_SUSPEND);
         cmd(1, `CMD_READ_STATUS);
         poll(1, `ST_READY_BIT, 1'b1);
         chk(got, st(1, 1, 0, 0, 0, 0), "suspended");
         cmd(1, `CMD_READ_ARRAY);
         rdchk(ba(0), `ARRAY_FILL, "other block read");
         if (o == 0) begin
            cmd(1, `CMD_READ_STATUS);
         end
         cmd(1, `CMD_CONFIRM);
         if (o == 1) begin
            cmd(1, `CMD_READ_STATUS);
         end
         rdchk(ba(1), st(0, 0, 0, 0, 0, 0), "resumed");
         poll(1, `ST_READY_BIT, 1'b1);
         chk(got, st(1, 0, 0, 0, 0, 0), "erase done");
      end
      cmd(1, `CMD_SUSPEND);
      cmd(1, `CMD_READ_STATUS);
      poll(1, `ST_READY_BIT, 1'b1);
      chk(got, st(1, 0, 0, 0, 0, 0), "late suspend");
      cmd(1, `CMD_READ_ARRAY);
      rdchk(ba(1), `ARRAY_FILL, "late suspend array");
      $display("test suspend done");
      cmd(3, `CMD_FACTORY);
      cmd(3, `CMD_CONFIRM);
      @(negedge i_clk);
      chk(16'(ready), 16'h0000, "factory busy");
      for (int g = 0; g < 2; g++) begin
         for (int w = 0; w < 32; w++) begin
            host.wr(ba(3), 16'($random(seed)));
         end
         rdchk(ba(3), st(0, 0, 0, 0, 0, 1), "group busy");
         poll(3, `ST_BBUSY_BIT, 1'b0);
         chk(got, st(0, 0, 0, 0, 0, 0), "group done");
      end
      host.wr(ba(4), `EXIT_WORD);
      poll(3, `ST_READY_BIT, 1'b1);
      chk(got, st(1, 0, 0, 0, 0, 0), "factory exit");
      $display("test factory done");
      cmd(5, `CMD_CONFIG);
      cmd(5, `CMD_PROTECT);
      for (int e = 0; e < 2; e++) begin
         @(posedge i_clk);
         i_vpp_ok <= (e == 1);
         repeat (6) @(posedge i_clk);
         cmd(6 - e, `CMD_FACTORY);
         cmd(6 - e, `CMD_CONFIRM);
         poll(6 - e, `ST_READY_BIT, 1'b1);
         chk(got, st(1, 0, 1, 1 - e, e, 0), "setup error");
         cmd(6 - e, `CMD_CLEAR_STAT);
         cmd(6 - e, `CMD_READ_STATUS);
         rdchk(ba(6 - e), st(1, 0, 0, 0, 0, 0), "cleared");
      end
      $display("test errors done");
      cmd(5, `CMD_PROGRAM);
      host.wr(ba(5), 16'($random(seed)));
      rdchk(ba(5), st(1, 0, 1, 0, 1, 0), "program to protected");
      cmd(5, `CMD_CLEAR_STAT);
      cmd(0, `CMD_PROGRAM_ALT);
      host.wr(ba(0) + 24'h000005, 16'($random(seed)));
      rdchk(ba(0), st(0, 0, 0, 0, 0, 0), "program busy");
      poll(0, `ST_READY_BIT, 1'b1);
      chk(got, st(1, 0, 0, 0, 0, 0), "program done");
      $display("test program done");
      give_verdict();
   end
endmodule : flash_command_sequences_tb
